/* logic/stl_defs.svh */
/*
 * Constants of the status and telemetry register bank: command codes,
 * field positions, reset values and timing counts.
 * Assumes it is included by bare name after the package is compiled.
 */
`ifndef STL_DEFS_SVH
`define STL_DEFS_SVH

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define STL_OFS_VIN_FLAGS    8'h7C
`define STL_OFS_THERM_FLAGS  8'h7D
`define STL_OFS_CML_FLAGS    8'h7E
`define STL_OFS_VIN_READ     8'h88
`define STL_OFS_VOUT_READ    8'h8B
`define STL_OFS_IOUT_READ    8'h8C
`define STL_OFS_TEMP_READ    8'h8D

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define STL_VIN_OVF_BIT      7
`define STL_VIN_OVW_BIT      6
`define STL_VIN_UVW_BIT      5
`define STL_OT_FAULT_BIT     7
`define STL_OT_WARN_BIT      6
`define STL_CML_BAD_CMD_BIT  7
`define STL_TEMP_SIGN_BIT    9
`define STL_FLAGS_RST        8'h00
`define STL_READING_RST      16'h0000
`define STL_MEAS_RST         10'h000

// ----------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------
`define STL_SYNC_STAGES      3
`define STL_RD_LATENCY       1

`endif

/* logic/stl_pkg.sv */
/*
 * Types shared by the status and telemetry register bank.
 * Assumes nothing of its surroundings.
 */
package stl_pkg;

    typedef logic [9:0] stl_meas_t;

    // Index of each sticky flag; the order fixes the generate loop.
    typedef enum {
        STL_F_VIN_OVF,
        STL_F_VIN_OVW,
        STL_F_VIN_UVW,
        STL_F_OT_FAULT,
        STL_F_OT_WARN,
        STL_F_OC_FAULT,
        STL_F_OC_WARN,
        STL_F_BAD_CMD,
        STL_F_COUNT
    } stl_flag_e;

    typedef struct packed {
        logic [15:0] rd_data;
        logic        rd_valid;
        logic        seen;
        stl_meas_t   vin;
        stl_meas_t   vout;
        stl_meas_t   iout;
        stl_meas_t   temp;
    } stl_state_s;

    typedef struct packed {
        logic flag;
    } stl_flag_s;

    typedef struct packed {
        logic [2:0] stage;
        logic       level;
    } stl_sync_s;

endpackage

/* logic/stl_pin_sync.sv */
/*
 * Three-stage synchroniser with agreement filter for one pin.
 * Assumes the pin is asynchronous to clk_sys_in.
 */
`timescale 1ns/1ps
module stl_pin_sync (
    input  wire logic clk_sys_in,
    input  wire logic nrst_in,
    input  wire logic ce_in,
    input  wire logic pin_in,
    output logic      level_out
);
    import stl_pkg::*;

    stl_sync_s state_ff;
    stl_sync_s nxt_state;

    // The first stage feeds only the second; the filter looks at stages two and three.
    always_comb begin
        nxt_state = state_ff;
        if (ce_in) begin
            nxt_state.stage = {state_ff.stage[1:0], pin_in};
            if (state_ff.stage[1] == state_ff.stage[2]) begin
                nxt_state.level = state_ff.stage[2];
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign level_out = state_ff.level;

endmodule // stl_pin_sync

/* logic/stl_sticky_flag.sv */
/*
 * One sticky status flag: set by its condition, cleared by clear-faults
 * only while the condition is absent.
 * Assumes cond_in and clear_in are on clk_sys_in.
 */
`timescale 1ns/1ps
module stl_sticky_flag (
    input  wire logic clk_sys_in,
    input  wire logic nrst_in,
    input  wire logic ce_in,
    input  wire logic cond_in,
    input  wire logic clear_in,
    output logic      flag_out
);
    import stl_pkg::*;

    stl_flag_s state_ff;
    stl_flag_s nxt_state;

    // A present condition beats the clear, so no event is lost.
    always_comb begin
        nxt_state = state_ff;
        if (ce_in) begin
            nxt_state.flag = cond_in | (state_ff.flag & ~clear_in);
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign flag_out = state_ff.flag;

endmodule // stl_sticky_flag

/* logic/stl_status_telemetry.sv */
/*
 * Read-only status and telemetry register bank of a power converter.
 * Holds latched input, thermal, current and command flags plus four
 * 10-bit readings, and answers command-code reads.
 * Assumes a bus engine on clk_sys_in decodes serial transactions into
 * one-cycle read commands and clear-faults pulses, and a measurement
 * engine delivers readings with a one-cycle valid pulse.
 */
`include "stl_defs.svh"
`timescale 1ns/1ps
module stl_status_telemetry #(
    parameter stl_pkg::stl_meas_t VIN_OV_WARN_LIM  = 10'h230,
    parameter stl_pkg::stl_meas_t VIN_UV_WARN_LIM  = 10'h130,
    parameter stl_pkg::stl_meas_t IOUT_OC_FLT_LIM  = 10'h2C0,
    parameter stl_pkg::stl_meas_t IOUT_OC_WARN_LIM = 10'h280,
    parameter stl_pkg::stl_meas_t OT_FAULT_LIM     = 10'h07D,
    parameter stl_pkg::stl_meas_t OT_WARN_LIM      = 10'h06E
) (
    input  wire logic               clk_sys_in,
    input  wire logic               nrst_in,
    input  wire logic               ce_in,
    input  wire logic               overvoltage_sense_pin_in,
    input  wire logic               meas_valid_in,
    input  wire stl_pkg::stl_meas_t vin_meas_in,
    input  wire stl_pkg::stl_meas_t vout_meas_in,
    input  wire stl_pkg::stl_meas_t iout_meas_in,
    input  wire stl_pkg::stl_meas_t temp_meas_in,
    input  wire logic               clear_faults_in,
    input  wire logic               cmd_valid_in,
    input  wire logic [7:0]         cmd_code_in,
    output logic                    rd_valid_out,
    output logic [15:0]             rd_data_out,
    output logic                    oc_fault_out,
    output logic                    oc_warn_out
);
    import stl_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    stl_state_s             state_ff;
    stl_state_s             nxt_state;
    logic                   ov_pin_level;
    logic [STL_F_COUNT-1:0] cond;
    logic [STL_F_COUNT-1:0] flag;
    logic [7:0]             vin_flags;
    logic [7:0]             therm_flags;
    logic [7:0]             cml_flags;
    logic [15:0]            rd_mux;
    logic                   code_known;

    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------
    stl_pin_sync u_ov_sync (
        .clk_sys_in (clk_sys_in),
        .nrst_in    (nrst_in),
        .ce_in      (ce_in),
        .pin_in     (overvoltage_sense_pin_in),
        .level_out  (ov_pin_level)
    );

    // ------------------------------------------------------------------
    // Fault and warning detection
    // ------------------------------------------------------------------
    // All but the pin and bad-command conditions work on the stored readings,
    // so what the host reads is exactly what tripped a flag. Readings of zero before the
    // first measurement would look like undervoltage, hence the seen gate.
    always_comb begin
        cond                 = '0;
        cond[STL_F_VIN_OVF]  = ov_pin_level;
        cond[STL_F_VIN_OVW]  = state_ff.seen &&
                               (state_ff.vin >= VIN_OV_WARN_LIM);
        cond[STL_F_VIN_UVW]  = state_ff.seen &&
                               (state_ff.vin < VIN_UV_WARN_LIM);
        cond[STL_F_OT_FAULT] = state_ff.seen &&
                               ($signed(state_ff.temp) >= $signed(OT_FAULT_LIM));
        cond[STL_F_OT_WARN]  = state_ff.seen &&
                               ($signed(state_ff.temp) >= $signed(OT_WARN_LIM));
        cond[STL_F_OC_FAULT] = state_ff.iout >= IOUT_OC_FLT_LIM;
        cond[STL_F_OC_WARN]  = state_ff.iout >= IOUT_OC_WARN_LIM;
        cond[STL_F_BAD_CMD]  = cmd_valid_in && !code_known;
    end

    // ------------------------------------------------------------------
    // Sticky flags
    // ------------------------------------------------------------------
    generate
        for (genvar i = 0; i < STL_F_COUNT; i++) begin : g_flag
            stl_sticky_flag u_flag (
                .clk_sys_in (clk_sys_in),
                .nrst_in    (nrst_in),
                .ce_in      (ce_in),
                .cond_in    (cond[i]),
                .clear_in   (clear_faults_in),
                .flag_out   (flag[i])
            );
        end
    endgenerate

    assign oc_fault_out = flag[STL_F_OC_FAULT];
    assign oc_warn_out  = flag[STL_F_OC_WARN];

    // ------------------------------------------------------------------
    // Register images
    // ------------------------------------------------------------------
    always_comb begin
        vin_flags                        = `STL_FLAGS_RST;
        vin_flags[`STL_VIN_OVF_BIT]      = flag[STL_F_VIN_OVF];
        vin_flags[`STL_VIN_OVW_BIT]      = flag[STL_F_VIN_OVW];
        vin_flags[`STL_VIN_UVW_BIT]      = flag[STL_F_VIN_UVW];
        therm_flags                      = `STL_FLAGS_RST;
        therm_flags[`STL_OT_FAULT_BIT]   = flag[STL_F_OT_FAULT];
        therm_flags[`STL_OT_WARN_BIT]    = flag[STL_F_OT_WARN];
        cml_flags                        = `STL_FLAGS_RST;
        cml_flags[`STL_CML_BAD_CMD_BIT]  = flag[STL_F_BAD_CMD];
    end

    // ------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------
    // Byte registers sit in the low byte with the high byte zero, so a
    // read-byte host simply takes bits 7 to 0.
    always_comb begin
        rd_mux     = `STL_READING_RST;
        code_known = 1'b1;
        case (cmd_code_in)
            `STL_OFS_VIN_FLAGS: begin
                rd_mux = {8'h00, vin_flags};
            end
            `STL_OFS_THERM_FLAGS: begin
                rd_mux = {8'h00, therm_flags};
            end
            `STL_OFS_CML_FLAGS: begin
                rd_mux = {8'h00, cml_flags};
            end
            `STL_OFS_VIN_READ: begin
                rd_mux = {6'h00, state_ff.vin};
            end
            `STL_OFS_VOUT_READ: begin
                rd_mux = {6'h00, state_ff.vout};
            end
            `STL_OFS_IOUT_READ: begin
                rd_mux = {6'h00, state_ff.iout};
            end
            `STL_OFS_TEMP_READ: begin
                rd_mux = {6'h00, state_ff.temp};
            end
            default: begin
                code_known = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        if (ce_in) begin
            nxt_state.rd_valid = cmd_valid_in;
            if (cmd_valid_in) begin
                nxt_state.rd_data = rd_mux;
            end
            // Readings change only with a measurement; reads never alter them.
            if (meas_valid_in) begin
                nxt_state.seen = 1'b1;
                nxt_state.vin  = vin_meas_in;
                nxt_state.vout = vout_meas_in;
                nxt_state.iout = iout_meas_in;
                nxt_state.temp = temp_meas_in;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign rd_valid_out = state_ff.rd_valid;
    assign rd_data_out  = state_ff.rd_data;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!nrst_in);

    vin_flag_hold_a: assert property (
        flag[STL_F_VIN_OVW] && !clear_faults_in |=> flag[STL_F_VIN_OVW])
        else $error("input warning flag dropped without clear-faults");

    ot_flag_hold_a: assert property (
        flag[STL_F_OT_FAULT] && cond[STL_F_OT_FAULT] |=> flag[STL_F_OT_FAULT])
        else $error("thermal fault flag cleared while condition present");

    ov_pin_latch_a: assert property (
        (ce_in && overvoltage_sense_pin_in)[*5] |=> flag[STL_F_VIN_OVF])
        else $error("overvoltage pin did not latch input bit 7");

    uv_warn_set_a: assert property (
        ce_in && state_ff.seen && state_ff.vin < VIN_UV_WARN_LIM
        |=> flag[STL_F_VIN_UVW] ##0 rd_valid_out == $past(cmd_valid_in))
        else $error("undervoltage warning not latched");

    vin_rsv_zero_a: assert property (
        ce_in && cmd_valid_in && cmd_code_in == `STL_OFS_VIN_FLAGS
        |=> rd_valid_out && rd_data_out[4:0] == 5'h00 && rd_data_out[15:8] == 8'h00
            && rd_data_out[6] == $past(flag[STL_F_VIN_OVW]))
        else $error("input status read wrong");

    therm_read_a: assert property (
        ce_in && cmd_valid_in && cmd_code_in == `STL_OFS_THERM_FLAGS
        |=> rd_data_out[5:0] == 6'h00
            && rd_data_out[7] == $past(flag[STL_F_OT_FAULT])
            && rd_data_out[6] == $past(flag[STL_F_OT_WARN]))
        else $error("thermal status read wrong");

    vin_read_a: assert property (
        ce_in && meas_valid_in ##1 ce_in && !meas_valid_in ##1
        ce_in && !meas_valid_in && cmd_valid_in && cmd_code_in == `STL_OFS_VIN_READ
        |=> rd_data_out == {6'h00, $past(vin_meas_in, 3)})
        else $error("input voltage reading not returned");

    oc_fault_set_a: assert property (
        ce_in && meas_valid_in && iout_meas_in >= IOUT_OC_FLT_LIM
        ##1 ce_in |=> oc_fault_out && oc_warn_out)
        else $error("overcurrent fault not flagged from reading");

    ot_detect_a: assert property (
        ce_in && state_ff.seen && $signed(state_ff.temp) >= $signed(OT_FAULT_LIM)
        |=> flag[STL_F_OT_FAULT])
        else $error("over-temperature fault not flagged from reading");

    ce_freeze_a: assert property (
        !ce_in |=> $stable(state_ff) && $stable(flag))
        else $error("state moved while clock enable low");

    // ------------------------------------------------------------------
    // Set, clear and read-back checks
    // ------------------------------------------------------------------
    // Every flag but the bad-command one and every word read is pinned down by an assertion, so a slip in the
    // decode shows in the cycle it happens rather than many reads later.
    ov_warn_set_a: assert property (
        ce_in && state_ff.seen && state_ff.vin >= VIN_OV_WARN_LIM |=> flag[STL_F_VIN_OVW])
        else $error("input overvoltage warning not latched");

    ovw_rise_a: assert property (
        $rose(flag[STL_F_VIN_OVW]) |-> $past(cond[STL_F_VIN_OVW]))
        else $error("input overvoltage warning set without its condition");

    uvw_clear_a: assert property (
        ce_in && clear_faults_in && !cond[STL_F_VIN_UVW] |=> !flag[STL_F_VIN_UVW])
        else $error("undervoltage warning survived clear-faults");

    ovf_keep_a: assert property (
        ce_in && clear_faults_in && ov_pin_level |=> flag[STL_F_VIN_OVF])
        else $error("overvoltage flag cleared while pin still high");

    ot_warn_set_a: assert property (
        ce_in && state_ff.seen && $signed(state_ff.temp) >= $signed(OT_WARN_LIM)
        |=> flag[STL_F_OT_WARN])
        else $error("over-temperature warning not flagged from reading");

    ot_clear_a: assert property (
        ce_in && clear_faults_in && !cond[STL_F_OT_WARN] |=> !flag[STL_F_OT_WARN])
        else $error("thermal warning survived clear-faults");

    oc_warn_set_a: assert property (
        ce_in && state_ff.iout >= IOUT_OC_WARN_LIM |=> oc_warn_out)
        else $error("overcurrent warning not flagged from reading");

    oc_clear_a: assert property (
        ce_in && clear_faults_in && state_ff.iout < IOUT_OC_WARN_LIM |=> !oc_warn_out)
        else $error("overcurrent warning survived clear-faults");

    vout_read_a: assert property (
        ce_in && cmd_valid_in && cmd_code_in == `STL_OFS_VOUT_READ
        |=> rd_data_out == {6'h00, $past(state_ff.vout)})
        else $error("output voltage reading not returned");

    iout_read_a: assert property (
        ce_in && cmd_valid_in && cmd_code_in == `STL_OFS_IOUT_READ
        |=> rd_data_out == {6'h00, $past(state_ff.iout)})
        else $error("current reading not returned");

    temp_read_a: assert property (
        ce_in && cmd_valid_in && cmd_code_in == `STL_OFS_TEMP_READ
        |=> rd_data_out == {6'h00, $past(state_ff.temp)})
        else $error("temperature reading not returned");

    word_hi_zero_a: assert property (
        ce_in && cmd_valid_in && cmd_code_in[7] |=> rd_data_out[15:10] == 6'h00)
        else $error("word read carries bits above the reading");

    readings_zero_a: assert property (
        !state_ff.seen |-> state_ff.vin == `STL_MEAS_RST && state_ff.vout == `STL_MEAS_RST
            && state_ff.iout == `STL_MEAS_RST && state_ff.temp == `STL_MEAS_RST)
        else $error("reading not zero before first measurement");

    bad_cmd_a: assert property (
        ce_in && cmd_valid_in && !code_known |=> rd_data_out == `STL_READING_RST)
        else $error("unmapped code did not answer zero");

    clear_cov_c:   cover property (flag[STL_F_VIN_OVF] ##1 clear_faults_in && ce_in
                                   ##1 !flag[STL_F_VIN_OVF]);
    bad_cmd_cov_c: cover property (ce_in && cmd_valid_in && !code_known);
    neg_temp_cov_c: cover property (state_ff.temp[`STL_TEMP_SIGN_BIT] && rd_valid_out);
    oc_cov_c:       cover property (ce_in && meas_valid_in ##2 oc_fault_out);
    ce_low_cov_c:   cover property (!ce_in && meas_valid_in);

endmodule // stl_status_telemetry

/* sim/stl_host_model.sv */
/*
 * Behavioural host of the power-management bus, reduced to the decoded
 * read requests and clear-faults pulses that reach the register bank.
 * Assumes the bank answers a read one clock after the request edge.
 */
`timescale 1ns/1ps
module stl_host_model (
    input  wire logic        clk_sys_in,
    input  wire logic        rd_valid_in,
    input  wire logic [15:0] rd_data_in,
    output logic             cmd_valid_out,
    output logic [7:0]       cmd_code_out,
    output logic             clear_faults_out
);
    initial begin
        cmd_valid_out    = 1'b0;
        cmd_code_out     = 8'hA5;
        clear_faults_out = 1'b0;
    end

    // ----------------------------------------------------------------------
    // Transactions
    // ----------------------------------------------------------------------
    // Every status byte is fetched as a single-byte read of its code. The
    // code lines carry the inverse once the request is over.
    task automatic read_cmd(input logic [7:0] code, output logic [15:0] data,
                            output logic ok);
        ok   = 1'b0;
        data = 16'hFFFF;
        @(posedge clk_sys_in);
        cmd_valid_out <= 1'b1;
        cmd_code_out  <= code;
        @(posedge clk_sys_in);
        cmd_valid_out <= 1'b0;
        cmd_code_out  <= ~code;
        for (int n = 0; n < 4 && ok == 1'b0; n++) begin
            @(negedge clk_sys_in);
            if (rd_valid_in === 1'b1) begin
                ok   = 1'b1;
                data = rd_data_in;
            end
        end
        // A valid that lingers past one cycle would double-count a byte.
        @(negedge clk_sys_in);
        if (rd_valid_in !== 1'b0) begin
            ok = 1'b0;
        end
    endtask

    task automatic clear_cmd();
        @(posedge clk_sys_in);
        clear_faults_out <= 1'b1;
        @(posedge clk_sys_in);
        clear_faults_out <= 1'b0;
    endtask
endmodule // stl_host_model

/* sim/stl_status_telemetry_bench.sv */
/*
 * Self-checking bench of the status and telemetry register bank.
 * Assumes the host model and the package are compiled beforehand.
 */
`timescale 1ns/1ps
module stl_status_telemetry_bench;
    import stl_pkg::*;

    typedef struct packed {
        logic [7:0]  code;
        logic [15:0] exp;
    } stl_row_s;

    logic        clk_sys;
    logic        nrst;
    logic        ce;
    logic        ovp;
    logic        mv;
    stl_meas_t   vin;
    stl_meas_t   vout;
    stl_meas_t   iout;
    stl_meas_t   temp;
    logic        clr;
    logic        cmd_valid;
    logic [7:0]  cmd_code;
    logic        rd_valid;
    logic [15:0] rd_data;
    logic        oc_fault;
    logic        oc_warn;
    int          n_errors;
    int          num_checks;
    stl_row_s    rows [7];

    stl_status_telemetry u_stl_status_telemetry (
        .clk_sys_in(clk_sys), .nrst_in(nrst), .ce_in(ce),
        .overvoltage_sense_pin_in(ovp), .meas_valid_in(mv),
        .vin_meas_in(vin), .vout_meas_in(vout), .iout_meas_in(iout),
        .temp_meas_in(temp), .clear_faults_in(clr), .cmd_valid_in(cmd_valid),
        .cmd_code_in(cmd_code), .rd_valid_out(rd_valid), .rd_data_out(rd_data),
        .oc_fault_out(oc_fault), .oc_warn_out(oc_warn)
    );

    stl_host_model u_stl_host_model (
        .clk_sys_in(clk_sys), .rd_valid_in(rd_valid), .rd_data_in(rd_data),
        .cmd_valid_out(cmd_valid), .cmd_code_out(cmd_code),
        .clear_faults_out(clr)
    );

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // ----------------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic rd(input logic [7:0] code, input logic [15:0] exp);
        logic [15:0] d;
        logic        ok;
        u_stl_host_model.read_cmd(code, d, ok);
        if (ok !== 1'b1) begin
            n_errors++;
            $display("ERROR %0t: no single-cycle answer to code %h", $time, code);
            complete_run();
        end else begin
            check(d, exp, "read data");
        end
    endtask

    task automatic meas(input stl_meas_t a, input stl_meas_t b, input stl_meas_t c,
                        input stl_meas_t d);
        @(posedge clk_sys);
        mv   <= 1'b1;
        vin  <= a;
        vout <= b;
        iout <= c;
        temp <= d;
        @(posedge clk_sys);
        mv   <= 1'b0;
    endtask

    task automatic pin(input logic lvl);
        @(posedge clk_sys);
        ovp <= lvl;
        // The pin filter settles within five edges; eight leaves margin.
        repeat (8) @(posedge clk_sys);
    endtask

    // ----------------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------------
    initial begin
        n_errors   = 0;
        num_checks = 0;
        nrst = 1'b0;
        ce   = 1'b1;
        ovp  = 1'b0;
        mv   = 1'b0;
        vin  = 10'h000;
        vout = 10'h000;
        iout = 10'h000;
        temp = 10'h000;
        rows = '{'{8'h88, 16'h01FF}, '{8'h8B, 16'h03FF}, '{8'h8C, 16'h0155},
                 '{8'h8D, 16'h03FF}, '{8'h7C, 16'h0000}, '{8'h7D, 16'h0000},
                 '{8'h7E, 16'h0000}};
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(rows[i].code, 16'h0000);
        end
        check({14'h0, oc_fault, oc_warn}, 16'h0000, "current flags at reset");
        meas(10'h1FF, 10'h3FF, 10'h155, 10'h3FF);
        for (int i = 0; i < 7; i++) begin
            rd(rows[i].code, rows[i].exp);
        end
        // Input warnings latch and clear one at a time.
        meas(10'h230, 10'h3FF, 10'h155, 10'h3FF);
        rd(8'h7C, 16'h0040);
        meas(10'h12F, 10'h3FF, 10'h155, 10'h3FF);
        rd(8'h7C, 16'h0060);
        u_stl_host_model.clear_cmd();
        rd(8'h7C, 16'h0020);
        meas(10'h1FF, 10'h3FF, 10'h155, 10'h3FF);
        rd(8'h7C, 16'h0020);
        u_stl_host_model.clear_cmd();
        rd(8'h7C, 16'h0000);
        // Overvoltage sense pin.
        pin(1'b1);
        rd(8'h7C, 16'h0080);
        u_stl_host_model.clear_cmd();
        rd(8'h7C, 16'h0080);
        pin(1'b0);
        rd(8'h7C, 16'h0080);
        u_stl_host_model.clear_cmd();
        rd(8'h7C, 16'h0000);
        // Thermal flags follow the stored temperature, signed.
        meas(10'h1FF, 10'h3FF, 10'h155, 10'h06E);
        rd(8'h7D, 16'h0040);
        meas(10'h1FF, 10'h3FF, 10'h155, 10'h07D);
        rd(8'h7D, 16'h00C0);
        meas(10'h1FF, 10'h3FF, 10'h155, 10'h200);
        rd(8'h7D, 16'h00C0);
        rd(8'h8D, 16'h0200);
        u_stl_host_model.clear_cmd();
        rd(8'h7D, 16'h0000);
        // Current limits.
        meas(10'h1FF, 10'h3FF, 10'h280, 10'h200);
        rd(8'h8C, 16'h0280);
        check({14'h0, oc_fault, oc_warn}, 16'h0001, "current warning");
        meas(10'h1FF, 10'h3FF, 10'h2C0, 10'h200);
        rd(8'h8C, 16'h02C0);
        check({14'h0, oc_fault, oc_warn}, 16'h0003, "current fault");
        meas(10'h1FF, 10'h3FF, 10'h000, 10'h200);
        u_stl_host_model.clear_cmd();
        rd(8'h8C, 16'h0000);
        check({14'h0, oc_fault, oc_warn}, 16'h0000, "current flags cleared");
        // Unmapped code answers zero and flags the command.
        rd(8'h99, 16'h0000);
        rd(8'h7E, 16'h0080);
        // A low clock enable must swallow a measurement and a clear.
        @(posedge clk_sys);
        ce <= 1'b0;
        meas(10'h000, 10'h000, 10'h2C0, 10'h07D);
        u_stl_host_model.clear_cmd();
        @(posedge clk_sys);
        ce <= 1'b1;
        rd(8'h7E, 16'h0080);
        rd(8'h88, 16'h01FF);
        check({14'h0, oc_fault, oc_warn}, 16'h0000, "flags moved with enable low");
        // A reset in mid-run must bring every register back to zero.
        meas(10'h1FF, 10'h3FF, 10'h2C0, 10'h07D);
        rd(8'h7D, 16'h00C0);
        check({14'h0, oc_fault, oc_warn}, 16'h0003, "current flags before reset");
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(rows[i].code, 16'h0000);
        end
        check({14'h0, oc_fault, oc_warn}, 16'h0000, "current flags after reset");
        complete_run();
    end
endmodule // stl_status_telemetry_bench
